// File: verilog/mem_pointer.sv
// Start-address pointer for the on-chip memories and the three sequential data ports.
// Assumes the serial control port logic on clk gives one-cycle read/write strobes and a
// one-cycle end-of-transaction pulse; the nonvolatile array and ROM answer one cycle
// after their read strobe.
`timescale 1ns/1ps
module mem_pointer #(
  parameter int SRAM_ADDR_W = mem_pointer_pkg::NVM_ADDR_W
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic txn_end,
  input wire logic [7:0] nvm_rdata,
  input wire logic [7:0] rom_rdata,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  output logic nvm_rd,
  output logic [8:0] nvm_addr,
  output logic rom_rd,
  output logic [11:0] rom_addr,
  output logic [11:0] memory_start_address
);

  // The array address ports are nine bits wide, so any other width is refused here
  if (SRAM_ADDR_W != mem_pointer_pkg::NVM_ADDR_W) begin
    $error("mem_pointer: SRAM address width must match the nonvolatile array");
  end

  // ----------------------------------------------------------------
  // Decode and cursor
  // ----------------------------------------------------------------
  logic [3:0] pointer_high;
  logic [7:0] pointer_low;
  logic [11:0] cursor;
  logic open;
  mem_pointer_pkg::port_t open_port;
  mem_pointer_pkg::port_t acc_port;
  logic [3:0] next_pointer_high;
  logic [7:0] next_pointer_low;
  logic [11:0] next_cursor;
  logic next_open;
  mem_pointer_pkg::port_t next_open_port;
  logic continuing;
  logic mem_hit;
  logic [11:0] base_addr;
  logic [11:0] pointer;

  assign pointer = {pointer_high, pointer_low};

  always_comb begin
    acc_port = mem_pointer_pkg::PORT_NONE;
    if (reg_rd || reg_wr) begin
      case (reg_addr)
        mem_pointer_pkg::OFF_POINTER_HIGH: acc_port = mem_pointer_pkg::PORT_PTR_HIGH;
        mem_pointer_pkg::OFF_POINTER_LOW: acc_port = mem_pointer_pkg::PORT_PTR_LOW;
        mem_pointer_pkg::OFF_NVM_DATA: acc_port = mem_pointer_pkg::PORT_NVM;
        mem_pointer_pkg::OFF_SRAM_DATA: acc_port = mem_pointer_pkg::PORT_SRAM;
        mem_pointer_pkg::OFF_ROM_DATA: acc_port = mem_pointer_pkg::PORT_ROM;
        default: acc_port = mem_pointer_pkg::PORT_NONE;
      endcase
    end
  end

  always_comb begin
    next_pointer_high = pointer_high;
    next_pointer_low = pointer_low;
    next_cursor = cursor;
    next_open = open;
    next_open_port = open_port;
    // upper nibble only, reserved bits dropped
    if (reg_wr && acc_port == mem_pointer_pkg::PORT_PTR_HIGH) begin
      next_pointer_high = reg_wdata[mem_pointer_pkg::HIGH_W-1:0];
    end
    if (reg_wr && acc_port == mem_pointer_pkg::PORT_PTR_LOW) begin
      next_pointer_low = reg_wdata;
    end
    // writes to the read-only ports touch nothing
    mem_hit = (reg_rd && (acc_port == mem_pointer_pkg::PORT_NVM || acc_port == mem_pointer_pkg::PORT_ROM)) ||
              ((reg_rd || reg_wr) && acc_port == mem_pointer_pkg::PORT_SRAM);
    continuing = open && open_port == acc_port;
    // first access at the pointer, later ones one past the cursor
    base_addr = continuing ? cursor + 12'h001 : pointer;
    if (mem_hit) begin
      next_cursor = base_addr;
      next_open = 1'b1;
      next_open_port = acc_port;
    end
    // an access in the closing cycle still counts, then the run ends
    if (txn_end) begin
      next_open = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pointer_high <= mem_pointer_pkg::POINTER_HIGH_RESET;
      pointer_low <= mem_pointer_pkg::POINTER_LOW_RESET;
      cursor <= 12'h000;
      open <= 1'b0;
      open_port <= mem_pointer_pkg::PORT_NONE;
    end else begin
      pointer_high <= next_pointer_high;
      pointer_low <= next_pointer_low;
      cursor <= next_cursor;
      open <= next_open;
      open_port <= next_open_port;
    end
  end

  // ----------------------------------------------------------------
  // Memory strobes and read pipeline
  // ----------------------------------------------------------------
  // Read data always lands three cycles after the request, so the control port
  // sees one fixed latency whichever register it touched.
  logic sram_we;
  logic sram_re;
  logic [8:0] sram_addr;
  logic [7:0] sram_wdata;
  logic [7:0] sram_rdata;
  mem_pointer_pkg::port_t s1_port;
  mem_pointer_pkg::port_t s2_port;
  logic s1_rd;
  logic s2_rd;
  logic next_nvm_rd;
  logic next_rom_rd;
  logic next_sram_we;
  logic next_sram_re;
  logic [8:0] next_nvm_addr;
  logic [11:0] next_rom_addr;
  logic [8:0] next_sram_addr;
  logic [7:0] next_reg_rdata;

  always_comb begin
    // the arrays see only the low nine bits; ROM sees all twelve
    next_nvm_addr = nvm_addr;
    next_rom_addr = rom_addr;
    next_sram_addr = sram_addr;
    // route each access to its own memory
    next_nvm_rd = mem_hit && acc_port == mem_pointer_pkg::PORT_NVM;
    next_rom_rd = mem_hit && acc_port == mem_pointer_pkg::PORT_ROM;
    next_sram_re = mem_hit && reg_rd && acc_port == mem_pointer_pkg::PORT_SRAM;
    next_sram_we = mem_hit && reg_wr && acc_port == mem_pointer_pkg::PORT_SRAM;
    if (next_nvm_rd) begin
      next_nvm_addr = base_addr[mem_pointer_pkg::NVM_ADDR_W-1:0];
    end
    if (next_rom_rd) begin
      next_rom_addr = base_addr;
    end
    if (next_sram_re || next_sram_we) begin
      next_sram_addr = base_addr[mem_pointer_pkg::NVM_ADDR_W-1:0];
    end
    case (s2_port)
      mem_pointer_pkg::PORT_PTR_HIGH: next_reg_rdata = {4'h0, pointer_high};
      mem_pointer_pkg::PORT_PTR_LOW: next_reg_rdata = pointer_low;
      mem_pointer_pkg::PORT_NVM: next_reg_rdata = nvm_rdata;
      mem_pointer_pkg::PORT_SRAM: next_reg_rdata = sram_rdata;
      mem_pointer_pkg::PORT_ROM: next_reg_rdata = rom_rdata;
      default: next_reg_rdata = mem_pointer_pkg::READ_ZERO;
    endcase
    if (!s2_rd) begin
      next_reg_rdata = reg_rdata;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      nvm_rd <= 1'b0;
      rom_rd <= 1'b0;
      sram_re <= 1'b0;
      sram_we <= 1'b0;
      nvm_addr <= 9'h000;
      rom_addr <= 12'h000;
      sram_addr <= 9'h000;
      sram_wdata <= 8'h00;
      s1_port <= mem_pointer_pkg::PORT_NONE;
      s2_port <= mem_pointer_pkg::PORT_NONE;
      s1_rd <= 1'b0;
      s2_rd <= 1'b0;
      reg_rdata <= 8'h00;
      reg_rvalid <= 1'b0;
      memory_start_address <= 12'h000;
    end else begin
      nvm_rd <= next_nvm_rd;
      rom_rd <= next_rom_rd;
      sram_re <= next_sram_re;
      sram_we <= next_sram_we;
      nvm_addr <= next_nvm_addr;
      rom_addr <= next_rom_addr;
      sram_addr <= next_sram_addr;
      sram_wdata <= reg_wdata;
      s1_port <= reg_rd ? acc_port : mem_pointer_pkg::PORT_NONE;
      s2_port <= s1_port;
      s1_rd <= reg_rd;
      s2_rd <= s1_rd;
      reg_rdata <= next_reg_rdata;
      reg_rvalid <= s2_rd;
      memory_start_address <= {next_pointer_high, next_pointer_low};
    end
  end

  sram_store #(
    .DATA_W(8),
    .ADDR_W(SRAM_ADDR_W)
  ) u_sram (
    .clk(clk),
    .we(sram_we),
    .re(sram_re),
    .addr(sram_addr),
    .wdata(sram_wdata),
    .rdata(sram_rdata)
  );

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic nvm_first;
  logic nvm_next;
  logic sram_next;
  logic rom_first;
  logic rom_next;
  assign nvm_first = next_nvm_rd && !continuing;
  assign nvm_next = next_nvm_rd && continuing;
  assign sram_next = (next_sram_re || next_sram_we) && continuing;
  assign rom_first = next_rom_rd && !continuing;
  assign rom_next = next_rom_rd && continuing;

  high_write_a: assert property (@(posedge clk) disable iff (!arst_n)
    (reg_wr && reg_addr == mem_pointer_pkg::OFF_POINTER_HIGH) |=> memory_start_address[11:8] == $past(reg_wdata[3:0]))
    else $error("pointer high nibble not stored");
  low_write_a: assert property (@(posedge clk) disable iff (!arst_n)
    (reg_wr && reg_addr == mem_pointer_pkg::OFF_POINTER_LOW) |=> pointer_low == $past(reg_wdata))
    else $error("pointer low byte not stored");
  nvm_start_a: assert property (@(posedge clk) disable iff (!arst_n)
    nvm_first |=> nvm_rd && nvm_addr == $past(memory_start_address[8:0]))
    else $error("nonvolatile run did not start at pointer");
  rom_start_a: assert property (@(posedge clk) disable iff (!arst_n)
    rom_first |=> rom_rd && rom_addr == $past(memory_start_address))
    else $error("ROM run did not start at full pointer");
  port_route_a: assert property (@(posedge clk) disable iff (!arst_n)
    $onehot0({nvm_rd, rom_rd, sram_re, sram_we}))
    else $error("more than one memory strobed");
  nvm_step_a: assert property (@(posedge clk) disable iff (!arst_n)
    nvm_next |=> {3'h0, nvm_addr} == (($past(cursor) + 12'h001) & 12'h1ff))
    else $error("nonvolatile address did not advance");
  sram_step_a: assert property (@(posedge clk) disable iff (!arst_n)
    sram_next |=> {3'h0, sram_addr} == (($past(cursor) + 12'h001) & 12'h1ff))
    else $error("SRAM address did not advance");
  rom_step_a: assert property (@(posedge clk) disable iff (!arst_n)
    rom_next |=> rom_addr == $past(cursor) + 12'h001)
    else $error("ROM address did not advance");
  txn_close_a: assert property (@(posedge clk) disable iff (!arst_n)
    txn_end |=> !open ##1 (!$past(mem_hit) || cursor == $past(pointer)))
    else $error("run not closed at transaction end");
  read_latency_a: assert property (@(posedge clk) disable iff (!arst_n)
    reg_rd |-> ##3 reg_rvalid)
    else $error("read answer late");

endmodule

// File: verilog/mem_pointer_pkg.sv
// Constants for the on-chip memory start-address pointer and its data ports.
// Assumes an 8-bit register address space driven by the serial control port logic.
package mem_pointer_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_POINTER_HIGH = 8'h8b;
  localparam logic [7:0] OFF_POINTER_LOW = 8'h8c;
  localparam logic [7:0] OFF_NVM_DATA = 8'h8d;
  localparam logic [7:0] OFF_SRAM_DATA = 8'h8e;
  localparam logic [7:0] OFF_ROM_DATA = 8'h8f;

  // ----------------------------------------------------------------
  // Field layout and reset values
  // ----------------------------------------------------------------
  localparam int PTR_W = 12;
  localparam int NVM_ADDR_W = 9;
  localparam int HIGH_W = 4;
  localparam logic [3:0] POINTER_HIGH_RESET = 4'h0;
  localparam logic [7:0] POINTER_LOW_RESET = 8'h00;
  localparam logic [7:0] READ_ZERO = 8'h00;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int READ_LATENCY = 3;

  // ----------------------------------------------------------------
  // Access targets
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    PORT_NONE,
    PORT_PTR_HIGH,
    PORT_PTR_LOW,
    PORT_NVM,
    PORT_SRAM,
    PORT_ROM
  } port_t;

endpackage

// File: verilog/sram_store.sv
// Small synchronous SRAM holding the shadow array of the nonvolatile memory.
// Assumes one access per cycle from a single owner; read data comes out of a register.
`timescale 1ns/1ps
module sram_store #(
  parameter int DATA_W = 8,
  parameter int ADDR_W = 9
) (
  input wire logic clk,
  input wire logic we,
  input wire logic re,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  output logic [DATA_W-1:0] rdata
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] cells [0:(1<<ADDR_W)-1];
  logic [DATA_W-1:0] next_rdata;

  // Arrays deeper than 16 address bits are refused at elaboration, as are empty data or address widths
  if (DATA_W < 1 || ADDR_W < 1 || ADDR_W > 16) begin
    $error("sram_store: unsupported geometry");
  end

  always_comb begin
    next_rdata = re ? cells[addr] : rdata;
  end

  // No reset on the array: contents come from the commit path, not from reset
  always_ff @(posedge clk) begin
    if (we) begin
      cells[addr] <= wdata;
    end
    rdata <= next_rdata;
  end

endmodule

// File: test/mem_model.sv
// Behavioural nonvolatile array and ROM at the far side of the pointer block.
// Assumes read strobes are sampled on clk; data is valid only in the cycle after one.
`timescale 1ns/1ps
module mem_model (
  input wire logic clk,
  input wire logic nvm_rd,
  input wire logic [8:0] nvm_addr,
  input wire logic rom_rd,
  input wire logic [11:0] rom_addr,
  output logic [7:0] nvm_rdata,
  output logic [7:0] rom_rdata
);
  // ----------------------------------------------------------------
  // Contents
  // ----------------------------------------------------------------
  function automatic logic [7:0] nvm_f(input logic [8:0] a);
    return a[7:0] ^ {7'h25, a[8]};
  endfunction

  function automatic logic [7:0] rom_f(input logic [11:0] a);
    return a[7:0] ^ {a[11:8], a[11:8]} ^ 8'h3c;
  endfunction

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  initial nvm_rdata = 8'h00;
  initial rom_rdata = 8'h00;
  // Outside the valid cycle the data toggles, so a late sample shows up
  always @(posedge clk) begin
    nvm_rdata <= nvm_rd ? nvm_f(nvm_addr) : ~nvm_rdata;
    rom_rdata <= rom_rd ? rom_f(rom_addr) : ~rom_rdata;
  end
endmodule

// File: test/tb.sv
// Self-checking bench for the memory start-address pointer and its data ports.
// Assumes the pointer block and the array model; reads are checked off a queue.
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin err_total++; \
  $display("wrong value %s expected %h seen %h", nm, ex, got); end end
module tb;
  logic clk = 0, arst_n = 0, reg_wr = 0, reg_rd = 0, txn_end = 0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00;
  logic [7:0] reg_rdata, nvm_rdata, rom_rdata;
  logic reg_rvalid, nvm_rd, rom_rd;
  logic [8:0] nvm_addr;
  logic [11:0] rom_addr, memory_start_address, ptr;
  logic [31:0] rs = 32'h00000047;
  logic [7:0] sdat [0:2];
  logic [7:0] expq [$];
  logic [7:0] e;
  int err_total = 0, n_compared = 0;

  always #12.5 clk = ~clk;

  mem_pointer mem_pointer_inst (.clk(clk), .arst_n(arst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .txn_end(txn_end), .nvm_rdata(nvm_rdata),
    .rom_rdata(rom_rdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .nvm_rd(nvm_rd),
    .nvm_addr(nvm_addr), .rom_rd(rom_rd), .rom_addr(rom_addr),
    .memory_start_address(memory_start_address));
  mem_model mem_model_inst (.clk(clk), .nvm_rd(nvm_rd), .nvm_addr(nvm_addr), .rom_rd(rom_rd),
    .rom_addr(rom_addr), .nvm_rdata(nvm_rdata), .rom_rdata(rom_rdata));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic void step();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
  endfunction

  // Strobes stay up between back-to-back calls; idle drops them
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #2;
    reg_wr = w;
    reg_rd = !w;
    reg_addr = a;
    reg_wdata = d;
  endtask

  task automatic idle(input logic t);
    @(posedge clk);
    #2;
    reg_wr = 0;
    reg_rd = 0;
    txn_end = t;
  endtask

  // Close the run without sharing its cycle with an access
  task automatic endt();
    idle(1);
    idle(0);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] x);
    expq.push_back(x);
    acc(0, a, 8'h00);
  endtask

  task automatic conclude();
    if (expq.size() != 0) err_total++;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Read answer monitor
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (reg_rvalid === 1'b1) begin
      e = (expq.size() > 0) ? expq.pop_front() : 8'hxx;
      `CHK("reg_rdata", e, reg_rdata)
    end
  end

  initial begin
    #(25 * 6000);
    err_total++;
    conclude();
  end

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    repeat (5) @(posedge clk);
    #2 arst_n = 1;
    `CHK("pointer", 12'h000, memory_start_address)
    rd(8'h8b, 8'h00);
    rd(8'h8c, 8'h00);
    rd(8'h90, 8'h00);
    idle(0);
    for (int i = 0; i < 6; i++) begin
      step();
      // Corner first: 9-bit wrap of the array cursor
      ptr = (i == 0) ? 12'hfff : rs[11:0];
      acc(1, mem_pointer_pkg::OFF_POINTER_HIGH, {rs[15:12], ptr[11:8]});
      acc(1, mem_pointer_pkg::OFF_POINTER_LOW, ptr[7:0]);
      // writes to read-only and unmapped ports ignored
      acc(1, 8'h8d, rs[23:16]);
      acc(1, 8'h8f, rs[31:24]);
      acc(1, 8'h90, 8'hff);
      idle(0);
      idle(0);
      `CHK("pointer", ptr, memory_start_address)
      rd(8'h8b, {4'h0, ptr[11:8]});
      rd(8'h8c, ptr[7:0]);
      for (int k = 0; k < 3; k++) rd(8'h8d, mem_model_inst.nvm_f(ptr[8:0] + 9'(k)));
      endt();
      rd(8'h8d, mem_model_inst.nvm_f(ptr[8:0]));
      for (int k = 0; k < 3; k++) rd(8'h8f, mem_model_inst.rom_f(ptr + 12'(k)));
      endt();
      for (int k = 0; k < 3; k++) begin
        step();
        sdat[k] = rs[7:0];
        acc(1, 8'h8e, sdat[k]);
      end
      endt();
      for (int k = 0; k < 3; k++) rd(8'h8e, sdat[k]);
      endt();
    end
    repeat (6) idle(0);
    conclude();
  end
endmodule
